// file: cpect_top.sv
// Purpose: Coprocessor-0 exception entry, return and cache tag staging
// Assumes: Core presents one committing instruction per cycle with its events
// Notes: Register reads answer one cycle after the select is presented

`timescale 1ns/1ps

// Contract
// [RULE_01] 32-bit readable, writable tag staging register with tag and parity.
// [RULE_02] Staging register loads from cache maintenance op and coprocessor move.
// [RULE_03] Indexed tag store ignores held parity and generates its own.
// [RULE_04] Tag field holds address bits 31:9 data, 31:11 instruction cache.
// [RULE_05] Line state: 0 invalid, 1 shared, 2 clean excl, 3 dirty excl.
// [RULE_06] Tag parity is even parity over the tag. Code covers bits 31:4, so the state, refill-order and lock bits are included.
// [RULE_07] Lock bit and refill-order bit kept in staging register.
// [RULE_08] Software writes zero into the reserved field.
// [RULE_09] All exceptions but the refill miss go to one general handler. Code sends error-class requests to the error vector.
// [RULE_10] Entry saves only resume address in return or error return PC.
// [RULE_11] Delay-slot fault saves branch address and sets delay-slot flag.
// [RULE_12] New return restores status and jumps; old one restores status only.
// [RULE_13] No hardware priority between interrupts; mask bits select them.
// [RULE_14] Only interrupts can be disabled; other exceptions always taken.
// [RULE_15] Program errors: illegal, disabled coprocessor, overflow, misalign, user segment.
// [RULE_16] Translation faults: invalid, write-protected store, missing entry.
// [RULE_17] Write-cycle bus error raises no exception.
// [RULE_18] Cache parity error sets status flag, raises no exception.
// [RULE_19] Configuration loaded from boot mode stream, mostly read-only.
// [RULE_20] Exception entry sets exception level, masking further interrupts.
module cpect_top (
    input wire logic clk_sys, // System clock, 10 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic cop_wr_en, // Move-in write strobe
    input wire logic [4:0] cop_wr_sel, // Move-in register number
    input wire logic [31:0] cop_wr_data, // Move-in data
    input wire logic [4:0] cop_rd_sel, // Move-out register number
    input wire logic cache_load_tag, // Index load tag into staging
    input wire logic [31:0] cache_tag_rdata, // Tag read from the cache
    input wire logic cache_store_tag, // Index store tag request
    input wire logic ex_valid, // Instruction at commit
    input wire logic [31:0] ex_pc, // Its address
    input wire logic ex_in_slot, // It sits in a branch delay slot
    input wire logic ev_illegal, // Illegal instruction
    input wire logic ev_cop, // Coprocessor instruction
    input wire logic [1:0] ev_cop_num, // Coprocessor it targets
    input wire logic ev_overflow, // Integer overflow
    input wire logic ev_misalign, // Misaligned address
    input wire logic acc_valid, // Memory access present
    input wire logic acc_outside_useg, // Access beyond user segment
    input wire logic ev_tlb_invalid, // Invalid translation used
    input wire logic ev_tlb_modified, // Store to protected page
    input wire logic ev_tlb_miss, // No matching translation
    input wire logic bus_err_rd, // Bus error on a read
    input wire logic bus_err_wr, // Bus error on a write
    input wire logic ev_syscall, // System call
    input wire logic ev_break, // Breakpoint
    input wire logic [5:0] irq_lines, // Hardware interrupt levels
    input wire logic err_req, // Error-class exception request
    input wire logic cache_parity_err, // Cache parity error seen
    input wire logic eret_op, // Return with jump
    input wire logic rfe_op, // Status restore only
    input wire logic boot_mode_valid, // Boot mode bit strobe
    input wire logic boot_mode_bit, // Boot mode serial bit
    output logic [31:0] cop_rd_data, // Registered read data
    output logic redirect_valid, // Fetch redirect pulse
    output logic [31:0] redirect_pc, // Redirect target
    output logic [4:0] exc_code, // Code of last general or refill exception; error entry leaves it unchanged
    output logic tag_store_valid, // Tag write pulse to cache
    output logic [31:0] tag_store_data // Tag with generated parity
);
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] cause;
        logic [31:0] exception_return_pc;
        logic [31:0] err_epc;
        logic [31:0] config_r;
        logic [31:0] rd_data;
        logic redir_v;
        logic [31:0] redir_pc;
    } cpect_top_state_t;

    cpect_top_state_t st_reg;
    cpect_top_state_t st_next;
    cpect_link_if lnk ();
    logic [31:0] resume_pc;
    logic [31:0] wr_merge;

    // ************************************************************
    // Submodules
    // ************************************************************
    cpect_tag_stage u_tag (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .lnk(lnk.tag_side)
    );

    cpect_exc_arb u_arb (
        .lnk(lnk.exc_side)
    );

    // [RULE_02] move and cache op requests
    assign lnk.mv_wr = cop_wr_en & (cop_wr_sel == cpect_pkg::REG_TAG);
    assign lnk.mv_data = cop_wr_data;
    assign lnk.ld_tag = cache_load_tag;
    assign lnk.ld_data = cache_tag_rdata;
    assign lnk.st_tag = cache_store_tag;

    // Event fan-in; write bus errors are never routed
    // [RULE_17] write bus error ignored
    assign lnk.ex_valid = ex_valid & ~err_req;
    assign lnk.illegal = ev_illegal;
    assign lnk.cop_instr = ev_cop;
    assign lnk.cop_num = ev_cop_num;
    assign lnk.overflow = ev_overflow;
    assign lnk.misalign = ev_misalign;
    // [RULE_15] user segment violation
    assign lnk.useg_viol = acc_valid & acc_outside_useg & st_reg.status[cpect_pkg::ST_UM];
    assign lnk.tlb_inv = ev_tlb_invalid;
    assign lnk.tlb_mod = ev_tlb_modified;
    assign lnk.tlb_miss = ev_tlb_miss;
    assign lnk.bus_rd = bus_err_rd;
    assign lnk.syscall = ev_syscall;
    assign lnk.brk = ev_break;
    assign lnk.ip = st_reg.cause[cpect_pkg::CA_IP_LSB +: cpect_pkg::NUM_IRQ];
    assign lnk.im = st_reg.status[cpect_pkg::ST_IM_LSB +: cpect_pkg::NUM_IRQ];
    assign lnk.cu = st_reg.status[cpect_pkg::ST_CU_LSB +: cpect_pkg::NUM_COP];
    assign lnk.ie = st_reg.status[cpect_pkg::ST_IE];
    assign lnk.exl = st_reg.status[cpect_pkg::ST_EXL];
    assign lnk.erl = st_reg.status[cpect_pkg::ST_ERL];
    assign lnk.um = st_reg.status[cpect_pkg::ST_UM];

    // ************************************************************
    // Helper terms
    // ************************************************************
    // [RULE_11] slot fault resumes at branch
    assign resume_pc = ex_in_slot ? (ex_pc - cpect_pkg::PC_STEP) : ex_pc;

    // Masked write data for status, used by the status write only
    assign wr_merge = (st_reg.status & ~cpect_pkg::STATUS_WR_MASK) |
                      (cop_wr_data & cpect_pkg::STATUS_WR_MASK);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        st_next.redir_v = 1'b0;

        // Software writes first; hardware events below override them
        if (cop_wr_en) begin
            case (cop_wr_sel)
                cpect_pkg::REG_STATUS: st_next.status = wr_merge;
                cpect_pkg::REG_CAUSE: begin
                    st_next.cause = (st_reg.cause & ~cpect_pkg::CAUSE_SW_MASK) |
                                    (cop_wr_data & cpect_pkg::CAUSE_SW_MASK);
                end
                cpect_pkg::REG_EPC: st_next.exception_return_pc = cop_wr_data;
                cpect_pkg::REG_ERR_EPC: st_next.err_epc = cop_wr_data;
                // [RULE_19] config mostly read-only
                cpect_pkg::REG_CONFIG: begin
                    st_next.config_r = (st_reg.config_r & ~cpect_pkg::CONFIG_SW_MASK) |
                                       (cop_wr_data & cpect_pkg::CONFIG_SW_MASK);
                end
                default: ;
            endcase
        end

        // [RULE_19] boot mode stream shift-in
        if (boot_mode_valid) begin
            st_next.config_r = {st_reg.config_r[30:0], boot_mode_bit};
        end

        // Hardware interrupt levels track the lines every cycle
        st_next.cause[cpect_pkg::CA_IP_LSB + cpect_pkg::NUM_SW_IRQ +: 6] = irq_lines;

        // [RULE_12] return paths
        if (eret_op | rfe_op) begin
            if (st_reg.status[cpect_pkg::ST_ERL]) begin
                st_next.status[cpect_pkg::ST_ERL] = 1'b0;
                st_next.redir_pc = st_reg.err_epc;
            end else begin
                st_next.status[cpect_pkg::ST_EXL] = 1'b0;
                st_next.redir_pc = st_reg.exception_return_pc;
            end
            st_next.redir_v = eret_op;
        end

        // [RULE_10] error entry saves error return PC
        if (err_req & ex_valid) begin
            st_next.err_epc = resume_pc;
            st_next.status[cpect_pkg::ST_ERL] = 1'b1;
            st_next.redir_v = 1'b1;
            st_next.redir_pc = cpect_pkg::ERROR_VEC_ADDR;
        end else if (lnk.take) begin
            // [RULE_10] only return PC saved
            if (!st_reg.status[cpect_pkg::ST_EXL]) begin
                st_next.exception_return_pc = resume_pc;
                // [RULE_11] delay-slot flag set
                st_next.cause[cpect_pkg::CA_BD] = ex_in_slot;
            end
            st_next.cause[cpect_pkg::CA_CODE_LSB +: 5] = lnk.code;
            // [RULE_20] entry raises exception level
            st_next.status[cpect_pkg::ST_EXL] = 1'b1;
            st_next.redir_v = 1'b1;
            // [RULE_09] single general handler
            st_next.redir_pc = lnk.refill ? cpect_pkg::REFILL_VEC_ADDR
                                          : cpect_pkg::GEN_VEC_ADDR;
        end

        // [RULE_18] parity flag only, set wins
        if (cache_parity_err) begin
            st_next.status[cpect_pkg::ST_PE] = 1'b1;
        end

        // Registered read port; staging register shows the live copy
        case (cop_rd_sel)
            cpect_pkg::REG_STATUS: st_next.rd_data = st_reg.status;
            cpect_pkg::REG_CAUSE: st_next.rd_data = st_reg.cause;
            cpect_pkg::REG_EPC: st_next.rd_data = st_reg.exception_return_pc;
            cpect_pkg::REG_ERR_EPC: st_next.rd_data = st_reg.err_epc;
            cpect_pkg::REG_CONFIG: st_next.rd_data = st_reg.config_r;
            // [RULE_01] staging register readable
            cpect_pkg::REG_TAG: st_next.rd_data = lnk.tag_q;
            default: st_next.rd_data = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '{status: cpect_pkg::STATUS_RESET, cause: cpect_pkg::CAUSE_RESET,
                        exception_return_pc: 32'h0000_0000, err_epc: 32'h0000_0000,
                        config_r: cpect_pkg::CONFIG_RESET, rd_data: 32'h0000_0000,
                        redir_v: 1'b0, redir_pc: 32'h0000_0000};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign cop_rd_data = st_reg.rd_data;
    assign redirect_valid = st_reg.redir_v;
    assign redirect_pc = st_reg.redir_pc;
    assign exc_code = st_reg.cause[cpect_pkg::CA_CODE_LSB +: 5];
    assign tag_store_valid = lnk.st_valid;
    assign tag_store_data = lnk.st_data;

endmodule // cpect_top

// file: cpect_pkg.sv
// Purpose: Shared constants and types for the coprocessor-0 exception and tag block
// Assumes: 32-bit datapath, coprocessor register numbers on a 5-bit select
// Notes: Vector addresses and encodings are plain defaults, easy to retarget

package cpect_pkg;

    // ************************************************************
    // Coprocessor register numbers
    // ************************************************************
    localparam logic [4:0] REG_STATUS = 5'h0C;
    localparam logic [4:0] REG_CAUSE = 5'h0D;
    localparam logic [4:0] REG_EPC = 5'h0E;
    localparam logic [4:0] REG_CONFIG = 5'h10;
    localparam logic [4:0] REG_TAG = 5'h1C;
    localparam logic [4:0] REG_ERR_EPC = 5'h1E;

    // ************************************************************
    // Status register fields
    // ************************************************************
    localparam int ST_IE = 0;
    localparam int ST_EXL = 1;
    localparam int ST_ERL = 2;
    localparam int ST_UM = 4;
    localparam int ST_IM_LSB = 8;
    localparam int ST_PE = 20;
    localparam int ST_CU_LSB = 28;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0004;
    localparam logic [31:0] STATUS_WR_MASK = 32'hF010_FF17;

    // ************************************************************
    // Cause register fields
    // ************************************************************
    localparam int CA_CODE_LSB = 2;
    localparam int CA_IP_LSB = 8;
    localparam int CA_BD = 31;
    localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
    localparam logic [31:0] CAUSE_SW_MASK = 32'h0000_0300;

    // ************************************************************
    // Configuration register
    // ************************************************************
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_SW_MASK = 32'h0000_0007;

    // ************************************************************
    // Cache tag staging register fields
    // ************************************************************
    localparam int TG_TAG_LSB = 8;
    localparam int TG_STATE_LSB = 6;
    localparam int TG_FIFO = 5;
    localparam int TG_LOCK = 4;
    localparam int TG_RSVD_LSB = 1;
    localparam int TG_PAR = 0;
    localparam int TG_PAR_LSB = 4;
    localparam logic [31:0] TAG_RESET = 32'h0000_0000;

    // ************************************************************
    // Exception codes, vectors and sizes
    // ************************************************************
    localparam logic [4:0] EC_INT = 5'h00;
    localparam logic [4:0] EC_TLB_MOD = 5'h01;
    localparam logic [4:0] EC_TLB_MISS = 5'h02;
    localparam logic [4:0] EC_TLB_INV = 5'h03;
    localparam logic [4:0] EC_ADDR = 5'h04;
    localparam logic [4:0] EC_BUS_RD = 5'h06;
    localparam logic [4:0] EC_SYSCALL = 5'h08;
    localparam logic [4:0] EC_BREAK = 5'h09;
    localparam logic [4:0] EC_ILLEGAL = 5'h0A;
    localparam logic [4:0] EC_COP = 5'h0B;
    localparam logic [4:0] EC_OVF = 5'h0C;
    localparam logic [31:0] GEN_VEC_ADDR = 32'h0000_0180;
    localparam logic [31:0] REFILL_VEC_ADDR = 32'h0000_0000;
    localparam logic [31:0] ERROR_VEC_ADDR = 32'h0000_0100;
    localparam logic [31:0] PC_STEP = 32'h0000_0004;
    localparam int NUM_IRQ = 8;
    localparam int NUM_SW_IRQ = 2;
    localparam int NUM_COP = 4;

    // Primary cache line states as held in the staging register
    typedef enum logic [1:0] {
        LS_INVALID = 2'h0,
        LS_SHARED = 2'h1,
        LS_CLEAN_EXCL = 2'h2,
        LS_DIRTY_EXCL = 2'h3
    } cpect_line_state_t;

endpackage

// file: cpect_link_if.sv
// Purpose: Carrier between the top and its tag and exception submodules
// Assumes: All members sampled on clk_sys
// Notes: Top drives requests, submodules answer

`timescale 1ns/1ps

interface cpect_link_if;
    // Tag staging side
    logic mv_wr;
    logic [31:0] mv_data;
    logic ld_tag;
    logic [31:0] ld_data;
    logic st_tag;
    logic [31:0] tag_q;
    logic st_valid;
    logic [31:0] st_data;
    // Exception side
    logic ex_valid;
    logic illegal, cop_instr, overflow, misalign, useg_viol;
    logic tlb_inv, tlb_mod, tlb_miss, bus_rd, syscall, brk;
    logic [1:0] cop_num;
    logic [cpect_pkg::NUM_IRQ-1:0] ip;
    logic [cpect_pkg::NUM_IRQ-1:0] im;
    logic [cpect_pkg::NUM_COP-1:0] cu;
    logic ie, exl, erl, um;
    logic take, refill;
    logic [4:0] code;

    modport tag_side (
        input mv_wr, mv_data, ld_tag, ld_data, st_tag,
        output tag_q, st_valid, st_data
    );
    modport exc_side (
        input ex_valid, illegal, cop_instr, overflow, misalign, useg_viol,
        input tlb_inv, tlb_mod, tlb_miss, bus_rd, syscall, brk, cop_num,
        input ip, im, cu, ie, exl, erl, um,
        output take, refill, code
    );
    modport core (
        output mv_wr, mv_data, ld_tag, ld_data, st_tag,
        input tag_q, st_valid, st_data,
        output ex_valid, illegal, cop_instr, overflow, misalign, useg_viol,
        output tlb_inv, tlb_mod, tlb_miss, bus_rd, syscall, brk, cop_num,
        output ip, im, cu, ie, exl, erl, um,
        input take, refill, code
    );
endinterface

// file: cpect_tag_stage.sv
// Purpose: Cache tag staging register with parity generation on tag store
// Assumes: Cache load has priority over a coprocessor move in the same cycle
// Notes: Store data is registered, one cycle after the request

`timescale 1ns/1ps

module cpect_tag_stage (
    input wire logic clk_sys, // System clock
    input wire logic reset_n, // Async reset, active low
    cpect_link_if.tag_side lnk // Tag requests and answers
);
    typedef struct packed {
        logic [31:0] tag;
        logic st_valid;
        logic [31:0] st_data;
    } cpect_tag_state_t;

    cpect_tag_state_t st_reg;
    cpect_tag_state_t st_next;
    logic gen_par;

    // ************************************************************
    // Next state
    // ************************************************************
    // [RULE_06] even tag parity
    assign gen_par = ^st_reg.tag[31:cpect_pkg::TG_PAR_LSB];

    // Loads, moves and tag store staging
    always_comb begin
        st_next = st_reg;
        st_next.st_valid = 1'b0;
        // [RULE_03] stored parity regenerated
        if (lnk.st_tag) begin
            st_next.st_valid = 1'b1;
            st_next.st_data = {st_reg.tag[31:cpect_pkg::TG_PAR + 1], gen_par};
        end
        // [RULE_04] [RULE_05] [RULE_07] fields kept whole
        // [RULE_02] cache op or move loads
        if (lnk.ld_tag) begin
            st_next.tag = lnk.ld_data;
        end else if (lnk.mv_wr) begin
            st_next.tag = lnk.mv_data;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '{tag: cpect_pkg::TAG_RESET, st_valid: 1'b0,
                        st_data: cpect_pkg::TAG_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign lnk.tag_q = st_reg.tag;
    assign lnk.st_valid = st_reg.st_valid;
    assign lnk.st_data = st_reg.st_data;
endmodule // cpect_tag_stage

// file: cpect_exc_arb.sv
// Purpose: Combinational exception classifier for the committing instruction
// Assumes: Event inputs qualify the instruction flagged by ex_valid
// Notes: Fixed order only among synchronous events; interrupts carry no order

`timescale 1ns/1ps

module cpect_exc_arb (
    cpect_link_if.exc_side lnk // Events in, decision out
);
    logic [cpect_pkg::NUM_IRQ-1:0] irq_hit;
    logic int_ok;
    logic cop_fault;

    // ************************************************************
    // Interrupt masking
    // ************************************************************
    // [RULE_13] per-line mask, no priority
    genvar gi;
    generate
        for (gi = 0; gi < cpect_pkg::NUM_IRQ; gi = gi + 1) begin : g_irq
            assign irq_hit[gi] = lnk.ip[gi] & lnk.im[gi];
        end
    endgenerate

    // [RULE_14] only interrupts maskable
    assign int_ok = (|irq_hit) & lnk.ie & ~lnk.exl & ~lnk.erl;

    // [RULE_15] coprocessor disabled check
    assign cop_fault = lnk.cop_instr & ~(lnk.cu[lnk.cop_num] |
                                         ((lnk.cop_num == 2'h0) & ~lnk.um));

    // Pick one cause; synchronous faults come before interrupts
    always_comb begin
        lnk.take = 1'b0;
        lnk.refill = 1'b0;
        lnk.code = cpect_pkg::EC_INT;
        if (lnk.ex_valid) begin
            lnk.take = 1'b1;
            // [RULE_15] program error causes
            if (lnk.illegal) begin
                lnk.code = cpect_pkg::EC_ILLEGAL;
            end else if (cop_fault) begin
                lnk.code = cpect_pkg::EC_COP;
            end else if (lnk.misalign | lnk.useg_viol) begin
                lnk.code = cpect_pkg::EC_ADDR;
            // [RULE_16] translation faults
            end else if (lnk.tlb_miss) begin
                lnk.code = cpect_pkg::EC_TLB_MISS;
                lnk.refill = ~lnk.exl;
            end else if (lnk.tlb_inv) begin
                lnk.code = cpect_pkg::EC_TLB_INV;
            end else if (lnk.tlb_mod) begin
                lnk.code = cpect_pkg::EC_TLB_MOD;
            end else if (lnk.bus_rd) begin
                lnk.code = cpect_pkg::EC_BUS_RD;
            end else if (lnk.overflow) begin
                lnk.code = cpect_pkg::EC_OVF;
            end else if (lnk.syscall) begin
                lnk.code = cpect_pkg::EC_SYSCALL;
            end else if (lnk.brk) begin
                lnk.code = cpect_pkg::EC_BREAK;
            end else if (int_ok) begin
                lnk.code = cpect_pkg::EC_INT;
            end else begin
                lnk.take = 1'b0;
            end
        end
    end
endmodule // cpect_exc_arb

// file: cpect_monitor.sv
// Purpose: Port assertions for cpect_top
// Assumes: One clock domain
// Notes: Bound below the module
`timescale 1ns/1ps
module cpect_monitor (
    input wire logic clk_sys, // Clock
    input wire logic reset_n, // Reset
    input wire logic ex_valid, // Commit
    input wire logic err_req, // Error
    input wire logic ev_illegal, // Illegal
    input wire logic ev_cop, // Cop op
    input wire logic ev_misalign, // Misalign
    input wire logic eret_op, // Return
    input wire logic cache_store_tag, // Store
    input wire logic redirect_valid, // Jump
    input wire logic [31:0] redirect_pc, // Target
    input wire logic [4:0] exc_code, // Code
    input wire logic tag_store_valid, // Stored
    input wire logic [31:0] tag_store_data // Data
);
    // One domain, so one default clock and reset
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_ill; ex_valid && ev_illegal && !err_req; endsequence
    sequence s_gen; redirect_valid && redirect_pc == cpect_pkg::GEN_VEC_ADDR; endsequence
    property p_gen; s_ill |=> s_gen; endproperty
    a_gen: assert property (p_gen) else $error("no general vector");
    property p_ill; s_ill |=> exc_code == cpect_pkg::EC_ILLEGAL; endproperty
    a_ill: assert property (p_ill) else $error("bad illegal code");
    property p_adr; ex_valid && ev_misalign && !(err_req || ev_illegal || ev_cop)
        |=> s_gen ##0 exc_code == cpect_pkg::EC_ADDR; endproperty
    a_adr: assert property (p_adr) else $error("bad address fault");
    property p_err; ex_valid && err_req
        |=> redirect_valid && redirect_pc == cpect_pkg::ERROR_VEC_ADDR; endproperty
    a_err: assert property (p_err) else $error("bad error entry");
    property p_ret; eret_op && !ex_valid |=> redirect_valid; endproperty
    a_ret: assert property (p_ret) else $error("return did not jump");
    property p_st; cache_store_tag |=> tag_store_valid; endproperty
    a_st: assert property (p_st) else $error("store not issued");
    property p_req; tag_store_valid |-> $past(cache_store_tag); endproperty
    a_req: assert property (p_req) else $error("store without request");
    property p_par; tag_store_valid |-> tag_store_data[0] == ^tag_store_data[31:4]; endproperty
    a_par: assert property (p_par) else $error("bad tag parity");
endmodule // cpect_monitor
bind cpect_top cpect_monitor u_mon (.clk_sys, .reset_n, .ex_valid, .err_req, .ev_illegal,
    .ev_cop, .ev_misalign, .eret_op, .cache_store_tag, .redirect_valid, .redirect_pc,
    .exc_code, .tag_store_valid, .tag_store_data);

// file: cpect_top_tb.sv
// Purpose: Directed bench for cpect_top
// Assumes: Inputs move on rising edges
// Notes: Expectations built here from constants
`timescale 1ns/1ps
module cpect_top_tb;
    logic clk_sys, reset_n, en, rv, tsv, hit;
    logic [4:0] wsel, rsel, code;
    logic [31:0] wdat, rdat, pc, tagi, rpc, tsd, d, t;
    logic [10:0] ev;
    logic [7:0] ctl; // slot valid eret rfe load store parity wrerr
    logic [5:0] irq;
    int err_total, checks;
    localparam logic [4:0] CODES [10] = '{5'h09, 5'h08, 5'h0C, 5'h06, 5'h01, 5'h03, 5'h02,
        5'h04, 5'h0B, 5'h0A};
    cpect_top dut (.clk_sys, .reset_n, .cop_wr_en(en), .cop_wr_sel(wsel), .cop_wr_data(wdat),
        .cop_rd_sel(rsel), .cache_load_tag(ctl[3]), .cache_tag_rdata(tagi),
        .cache_store_tag(ctl[2]), .ex_valid(ctl[6]), .ex_pc(pc), .ex_in_slot(ctl[7]),
        .ev_illegal(ev[9]), .ev_cop(ev[8]), .ev_cop_num(2'h1), .ev_overflow(ev[2]),
        .ev_misalign(ev[7]), .acc_valid(1'b0), .acc_outside_useg(1'b0),
        .ev_tlb_invalid(ev[5]), .ev_tlb_modified(ev[4]), .ev_tlb_miss(ev[6]),
        .bus_err_rd(ev[3]), .bus_err_wr(ctl[0]), .ev_syscall(ev[1]), .ev_break(ev[0]),
        .irq_lines(irq), .err_req(ev[10]), .cache_parity_err(ctl[1]), .eret_op(ctl[5]),
        .rfe_op(ctl[4]), .boot_mode_valid(1'b0), .boot_mode_bit(1'b0), .cop_rd_data(rdat),
        .redirect_valid(rv), .redirect_pc(rpc), .exc_code(code), .tag_store_valid(tsv),
        .tag_store_data(tsd));
    // Clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wr(input logic [4:0] s, input logic [31:0] v);
        @(posedge clk_sys) begin en <= 1'b1; wsel <= s; wdat <= v; end
        @(posedge clk_sys) en <= 1'b0;
    endtask
    // Read data lands one cycle after the select is presented
    task rd(input logic [4:0] s);
        @(posedge clk_sys) rsel <= s;
        @(posedge clk_sys);
        #1 d = rdat;
    endtask
    task op(input logic [7:0] c, input logic [10:0] e, input logic [31:0] p);
        @(posedge clk_sys) begin ctl <= c; ev <= e; pc <= p; end
        @(posedge clk_sys) begin ctl <= '0; ev <= '0; end
        #1;
    endtask
    // Drive empty commits and watch for any redirect over n cycles
    task wt(input int n);
        hit = 1'b0;
        repeat (n) begin
            @(posedge clk_sys) ctl <= 8'h40;
            #1 hit = hit | rv;
        end
        @(posedge clk_sys) ctl <= '0;
    endtask
    initial begin
        {en, wsel, rsel, wdat, pc, tagi, ev, ctl, irq} = '0;
        reset_n = 1'b0;
        err_total = 0;
        checks = 0;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        wr(cpect_pkg::REG_STATUS, 32'h0);
        for (int i = 0; i < 11; i++) begin
            op(8'h40, 11'(1 << i), 32'h1000 + 32'(i) * 32'h10);
            d = i == 6 ? cpect_pkg::REFILL_VEC_ADDR : cpect_pkg::GEN_VEC_ADDR;
            chk(rpc, i == 10 ? cpect_pkg::ERROR_VEC_ADDR : d);
            if (i < 10) chk(code, CODES[i]);
            op(8'h20, '0, pc);
            chk(rpc, pc);
        end
        op(8'hC0, 11'h001, 32'h2004);
        rd(cpect_pkg::REG_EPC);
        chk(d, 32'h2000);
        rd(cpect_pkg::REG_CAUSE);
        chk(d[31], 1'b1);
        wr(cpect_pkg::REG_STATUS, 32'h0403);
        @(posedge clk_sys) irq <= 6'h01;
        wt(4);
        chk(hit, 1'b0);
        op(8'h40, 11'h001, 32'h3000);
        chk(code, 5'h09);
        op(8'h10, '0, pc);
        chk(rv, 1'b0);
        wt(6);
        chk(hit, 1'b1);
        wr(cpect_pkg::REG_STATUS, 32'h1);
        wt(4);
        chk(hit, 1'b0);
        op(8'h43, '0, pc);
        chk(rv, 1'b0);
        rd(cpect_pkg::REG_STATUS);
        chk(d[20], 1'b1);
        $display("exception tests done");
        for (int k = 0; k < 4; k++) begin
            t = {24'hA5C30F ^ 24'(k), 2'(k), 6'h21};
            wr(cpect_pkg::REG_TAG, t);
            op(8'h04, '0, pc);
            chk(tsd, {t[31:1], ^t[31:4]});
            rd(cpect_pkg::REG_TAG);
            chk(d, t);
        end
        @(posedge clk_sys) tagi <= 32'h1234_5610;
        op(8'h08, '0, pc);
        rd(cpect_pkg::REG_TAG);
        chk(d, 32'h1234_5610);
        $display("tag tests done");
        wrap_up;
    end
    // Watchdog, far beyond the roughly 120 cycles used
    initial begin
        #1000000;
        err_total++;
        wrap_up;
    end
endmodule // cpect_top_tb
